/* logic/sarb_register_bank.sv */
// Register bank of the sensor acquisition device
//
// Functional notes
// RULE1 - Results are 16-bit two's complement, saturated to 0x7fff or 0x8000.
// RULE2 - Zero input gives 0000, full scale 7fff and 8000.
// RULE3 - Below 16-bit resolution low result bits take a fixed pattern.
// RULE4 - Converter bias codes 00, 01, 11 select quarter, half, full current.
// RULE5 - Host keeps sampling rate within limit of present bias setting.
// RULE6 - Amplifier bias uses the same encoding as converter bias.
// RULE7 - Amplifiers and converter can be disabled entirely for minimum power.
// RULE8 - Decode 0x30, 0x40, 0x41, 0x50 to 0x57 and 0x70.
// RULE9 - Unused bits ignore writes and affect nothing.
// RULE10 - Reset loads every register with its reset value.
// RULE11 - Oscillator enable bit 0 resets to 1; bits 7:1 read zero.
// RULE12 - Pad output bits 7:4 are pad directions, reset to 1.
// RULE13 - Bits 3 and 2 drive pads 3 and 2 when set as outputs.
// RULE14 - Bit 1 drives pad 1 only if output and no external reference.
// RULE15 - Bit 0 drives pad 0 only if output and no reference output.
// RULE16 - Mode bit 1 routes reference to pad 0, bit 0 takes it on pad 1.
// RULE17 - Pad input register returns live pad levels, upper bits zero.
// RULE18 - Result low byte at 0x50, read-only, resets to zero.
// RULE19 - Result high byte at 0x51, read-only.
// RULE20 - Host combines the result bytes into one word.
// RULE21 - Writes to read-only registers or bits change nothing.
`include "sarb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sarb_register_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sarb_pkg::sarb_bus_req_type bus_i,
  output logic [7:0] rdata_o,
  input wire logic [3:0] pad_level_i,
  output sarb_pkg::sarb_pad_drive_type pad_o,
  input wire sarb_pkg::sarb_sample_type sample_i,
  input wire logic busy_i,
  input wire logic [1:0] pump_status_i,
  output logic osc_on_o,
  output sarb_pkg::sarb_bias_type converter_bias_o,
  output sarb_pkg::sarb_bias_type amplifier_bias_o,
  output logic analog_off_o,
  output logic reference_out_on_pad0_o,
  output logic reference_in_on_pad1_o,
  output logic [7:0] config_b_o,
  output logic [7:0] config_c_o,
  output logic [7:0] config_d_o,
  output logic [6:0] config_e_o,
  output logic [6:0] config_f_o,
  output logic [3:0] mode_high_o
);
  import sarb_pkg::*;

  // ==========================================
  // Storage
  logic osc_on;
  logic [7:0] pad_out_dir;
  logic [15:0] result;
  logic [6:0] conv_config_a;
  logic [7:0] conv_config_b;
  logic [7:0] conv_config_c;
  logic [7:0] conv_config_d;
  logic [6:0] conv_config_e;
  logic [6:0] conv_config_f;
  logic [5:0] chip_operating_mode;
  logic [7:0] next_rdata;
  logic [15:0] next_result;
  logic wr;

  assign wr = bus_i.write;

  // ==========================================
  // Helpers
  function automatic sarb_bias_type bias_decode(input logic [1:0] code);
    bias_decode = SARB_BIAS_F;
    if (code == `SARB_BIAS_QUARTER) begin
      bias_decode = SARB_BIAS_Q;
    end else if (code == `SARB_BIAS_HALF) begin
      bias_decode = SARB_BIAS_H;
    end
  endfunction

  // Number of forced low bits: 16 minus resolution, none at full width
  function automatic logic [4:0] forced_bits(input logic [2:0] osr, input logic [1:0] nelc);
    logic [4:0] res;
    // Widen before adding so the sum cannot wrap at four bits
    res = 5'({osr, 1'b0}) + 5'h6 + 5'(nelc);
    if (res >= `SARB_NO_FORCE) begin
      forced_bits = 5'h0;
    end else begin
      forced_bits = 5'(`SARB_NO_FORCE - res);
    end
  endfunction

  // ==========================================
  // Result capture
  always_comb begin
    logic [4:0] nf;
    logic [15:0] mask;
    // Stored bit k is bus bit k+1
    nf = forced_bits(conv_config_a[3:1], conv_config_a[5:4]);
    next_result = `SARB_ZERO_CODE;
    if (sample_i.raw > $signed(18'(`SARB_POS_FULL))) begin
      next_result = `SARB_POS_FULL; // [RULE1] [RULE2]
    end else if (sample_i.raw < -$signed(18'(`SARB_NEG_FULL))) begin
      next_result = `SARB_NEG_FULL; // [RULE1] [RULE2]
    end else begin
      next_result = sample_i.raw[15:0];
    end
    mask = 16'((17'h1 << nf) - 17'h1);
    if (nf != 5'h0) begin
      // Pattern is one followed by zeros
      next_result = (next_result & ~mask) | 16'(17'h1 << (nf - 5'h1)); // [RULE3]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      result <= 16'h0000; // [RULE10] [RULE18]
    end else if (sample_i.valid) begin
      result <= next_result;
    end
  end

  // ==========================================
  // Writable registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_on <= `SARB_RST_OSC; // [RULE10] [RULE11]
    end else if (wr && bus_i.addr == `SARB_ADDR_OSC) begin
      osc_on <= bus_i.wdata[0]; // [RULE9] [RULE11]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_out_dir <= `SARB_RST_PAD_OUT; // [RULE10] [RULE12]
    end else if (wr && bus_i.addr == `SARB_ADDR_PAD_OUT) begin
      pad_out_dir <= bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_config_a <= `SARB_RST_CFG_A;
      conv_config_b <= `SARB_RST_CFG_B;
      conv_config_c <= `SARB_RST_CFG_C;
      conv_config_d <= `SARB_RST_CFG_D;
      conv_config_e <= `SARB_RST_CFG_E;
      conv_config_f <= `SARB_RST_CFG_F;
      chip_operating_mode <= `SARB_RST_MODE; // [RULE10] [RULE16]
    end else if (wr) begin
      // Read-only bits are not stored
      unique case (bus_i.addr)
        `SARB_ADDR_CFG_A: conv_config_a <= bus_i.wdata[7:1]; // [RULE9]
        `SARB_ADDR_CFG_B: conv_config_b <= bus_i.wdata;
        `SARB_ADDR_CFG_C: conv_config_c <= bus_i.wdata;
        `SARB_ADDR_CFG_D: conv_config_d <= bus_i.wdata;
        `SARB_ADDR_CFG_E: conv_config_e <= bus_i.wdata[6:0]; // [RULE9]
        `SARB_ADDR_CFG_F: conv_config_f <= bus_i.wdata[6:0]; // [RULE21]
        `SARB_ADDR_MODE: chip_operating_mode <= bus_i.wdata[5:0]; // [RULE21]
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // Read path
  always_comb begin
    next_rdata = 8'h00;
    unique case (bus_i.addr) // [RULE8]
      `SARB_ADDR_OSC: next_rdata = {7'h00, osc_on}; // [RULE11]
      `SARB_ADDR_PAD_OUT: next_rdata = pad_out_dir;
      `SARB_ADDR_PAD_IN: next_rdata = {4'h0, pad_level_i}; // [RULE17]
      `SARB_ADDR_RES_LO: next_rdata = result[7:0]; // [RULE18] [RULE20]
      `SARB_ADDR_RES_HI: next_rdata = result[15:8]; // [RULE19] [RULE20]
      `SARB_ADDR_CFG_A: next_rdata = {conv_config_a, 1'b0};
      `SARB_ADDR_CFG_B: next_rdata = conv_config_b;
      `SARB_ADDR_CFG_C: next_rdata = conv_config_c;
      `SARB_ADDR_CFG_D: next_rdata = conv_config_d;
      `SARB_ADDR_CFG_E: next_rdata = {1'b0, conv_config_e};
      `SARB_ADDR_CFG_F: next_rdata = {busy_i, conv_config_f};
      `SARB_ADDR_MODE: next_rdata = {pump_status_i, chip_operating_mode};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.read) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ==========================================
  // Pads and analog controls
  always_comb begin
    pad_o.out = pad_out_dir[3:0];
    pad_o.oe[3] = pad_out_dir[7]; // [RULE13]
    pad_o.oe[2] = pad_out_dir[6]; // [RULE13]
    pad_o.oe[1] = pad_out_dir[5] && !chip_operating_mode[`SARB_MODE_REF_IN]; // [RULE14]
    pad_o.oe[0] = pad_out_dir[4] && !chip_operating_mode[`SARB_MODE_REF_OUT]; // [RULE15]
  end

  assign osc_on_o = osc_on;
  assign converter_bias_o = bias_decode(conv_config_b[7:6]); // [RULE4]
  assign amplifier_bias_o = bias_decode(conv_config_b[5:4]); // [RULE6]
  assign analog_off_o = conv_config_b[3:0] == `SARB_ENABLE_OFF; // [RULE7]
  assign reference_out_on_pad0_o = chip_operating_mode[`SARB_MODE_REF_OUT]; // [RULE16]
  assign reference_in_on_pad1_o = chip_operating_mode[`SARB_MODE_REF_IN]; // [RULE16]
  assign config_b_o = conv_config_b;
  assign config_c_o = conv_config_c;
  assign config_d_o = conv_config_d;
  assign config_e_o = conv_config_e;
  assign config_f_o = conv_config_f;
  assign mode_high_o = chip_operating_mode[5:2];

  // ==========================================
  // Checks
  a_osc_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && bus_i.addr == `SARB_ADDR_OSC |=> osc_on == $past(bus_i.wdata[0])) // [RULE11]
    else $error("oscillator bit not updated");
  a_pad_in_read: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.read && bus_i.addr == `SARB_ADDR_PAD_IN |=> rdata_o[7:4] == 4'h0 && rdata_o[3:0] == $past(pad_level_i))
    else $error("pad input readback wrong"); // [RULE17]
  a_ro_result: assert property (@(posedge clk_i) disable iff (rst_i)
    !sample_i.valid |=> result == $past(result)) // [RULE21]
    else $error("result changed without sample");
  a_sat_pos: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_i.valid && sample_i.raw > 18'sh07fff |=> result[15:12] == 4'h7) // [RULE1]
    else $error("positive saturation wrong");
  a_pad1_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    chip_operating_mode[0] |-> !pad_o.oe[1]) // [RULE14]
    else $error("pad 1 driven with reference input");
  a_pad0_ref: assert property (@(posedge clk_i) disable iff (rst_i)
    chip_operating_mode[1] |-> !pad_o.oe[0]) // [RULE15]
    else $error("pad 0 driven with reference output");
  a_pad_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && bus_i.addr == `SARB_ADDR_PAD_OUT |=> pad_o.oe[3:2] == $past(bus_i.wdata[7:6])) // [RULE13]
    else $error("pad direction not applied");
  a_hi_read: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_i.read && bus_i.addr == `SARB_ADDR_RES_HI && !sample_i.valid |=> rdata_o == result[15:8]) // [RULE19]
    else $error("result high byte readback wrong");
  a_bias_half: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_config_b[7:6] == 2'h1 |-> converter_bias_o == SARB_BIAS_H) // [RULE4]
    else $error("bias decode wrong");
endmodule
`default_nettype wire

/* logic/sarb_map.svh */
// Register offsets, field positions, reset values and code constants
`ifndef SARB_MAP_SVH
`define SARB_MAP_SVH
`define SARB_ADDR_OSC 8'h30
`define SARB_ADDR_PAD_OUT 8'h40
`define SARB_ADDR_PAD_IN 8'h41
`define SARB_ADDR_RES_LO 8'h50
`define SARB_ADDR_RES_HI 8'h51
`define SARB_ADDR_CFG_A 8'h52
`define SARB_ADDR_CFG_B 8'h53
`define SARB_ADDR_CFG_C 8'h54
`define SARB_ADDR_CFG_D 8'h55
`define SARB_ADDR_CFG_E 8'h56
`define SARB_ADDR_CFG_F 8'h57
`define SARB_ADDR_MODE 8'h70
`define SARB_RST_OSC 1'h1
`define SARB_RST_PAD_OUT 8'hf0
`define SARB_RST_CFG_A 7'h14
`define SARB_RST_CFG_B 8'hf0
`define SARB_RST_CFG_C 8'h00
`define SARB_RST_CFG_D 8'h0c
`define SARB_RST_CFG_E 7'h00
`define SARB_RST_CFG_F 7'h00
`define SARB_RST_MODE 6'h04
`define SARB_POS_FULL 16'h7fff
`define SARB_NEG_FULL 16'h8000
`define SARB_ZERO_CODE 16'h0000
`define SARB_BIAS_QUARTER 2'h0
`define SARB_BIAS_HALF 2'h1
`define SARB_BIAS_FULL 2'h3
`define SARB_ENABLE_OFF 4'h0
`define SARB_MODE_REF_OUT 1
`define SARB_MODE_REF_IN 0
`define SARB_NO_FORCE 5'h10
`endif

/* logic/sarb_pkg.sv */
// Types shared by the register bank
package sarb_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } sarb_bus_req_type;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } sarb_pad_drive_type;
  typedef struct packed {
    logic signed [17:0] raw;
    logic valid;
  } sarb_sample_type;
  typedef enum logic [2:0] {
    SARB_BIAS_Q = 3'b001,
    SARB_BIAS_H = 3'b010,
    SARB_BIAS_F = 3'b100
  } sarb_bias_type;
endpackage

/* tb/sarb_pad_model.sv */
// Pad partner: resolves each pad from device drive and outside driver
`timescale 1ns/1ps
`default_nettype none
module sarb_pad_model (
  input wire sarb_pkg::sarb_pad_drive_type pad_i,
  input wire logic [3:0] ext_i,
  output logic [3:0] level_o
);
  import sarb_pkg::*;
  // ==========
  // Device wins where it drives, the outside source elsewhere
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      level_o[k] = pad_i.oe[k] ? pad_i.out[k] : ext_i[k];
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sarb_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} sarb_row_type;
  logic clk_i, rst_i, busy, osc_on, analog_off, ref_out, ref_in;
  logic [1:0] pump;
  logic [3:0] ext, level, mode_hi;
  logic [7:0] cfg_b, cfg_c, cfg_d;
  logic [6:0] cfg_e, cfg_f;
  logic [7:0] rdata, got;
  sarb_bus_req_type bus;
  sarb_pad_drive_type pad;
  sarb_sample_type smp;
  sarb_bias_type conv_bias, amp_bias;
  int miscompares, tests_run;
  sarb_row_type rows [8] = '{'{8'h30, 8'hfe, 8'h00}, '{8'h30, 8'h01, 8'h01}, '{8'h50, 8'hff, 8'h00},
    '{8'h51, 8'hff, 8'h00}, '{8'h54, 8'ha5, 8'ha5}, '{8'h42, 8'hff, 8'h00}, '{8'h52, 8'h6d, 8'h6c},
    '{8'h40, 8'h5a, 8'h5a}};
  logic [15:0] rv [12] = '{16'h3001, 16'h40f0, 16'h4100, 16'h5000, 16'h5100, 16'h5228, 16'h53f0,
    16'h5400, 16'h550c, 16'h5600, 16'h5780, 16'h7084};
  logic [1:0] cd [3] = '{2'h0, 2'h1, 2'h3};
  sarb_bias_type oh [3] = '{SARB_BIAS_Q, SARB_BIAS_H, SARB_BIAS_F};

  sarb_register_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .pad_level_i(level), .pad_o(pad), .sample_i(smp), .busy_i(busy), .pump_status_i(pump),
    .osc_on_o(osc_on), .converter_bias_o(conv_bias), .amplifier_bias_o(amp_bias),
    .analog_off_o(analog_off), .reference_out_on_pad0_o(ref_out), .reference_in_on_pad1_o(ref_in),
    .config_b_o(cfg_b), .config_c_o(cfg_c), .config_d_o(cfg_d), .config_e_o(cfg_e), .config_f_o(cfg_f),
    .mode_high_o(mode_hi));
  sarb_pad_model i_pads (.pad_i(pad), .ext_i(ext), .level_o(level));

  // ==========
  // Bus and compare tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk_i);
    bus.write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clk_i);
    bus.read <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic put(input logic [17:0] r, input logic [15:0] e);
    logic [7:0] lo;
    @(posedge clk_i);
    smp <= '{raw: r, valid: 1'b1};
    @(posedge clk_i);
    smp.valid <= 1'b0;
    rd(8'h50);
    lo = got;
    rd(8'h51);
    chk({got, lo}, e);
  endtask
  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========
  // Clock, watchdog and main sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    print_verdict();
  end
  initial begin
    rst_i = 1'b1;
    bus = '0;
    smp = '0;
    busy = 1'b1;
    pump = 2'h2;
    ext = 4'hf;
    miscompares = 0;
    tests_run = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(got, rows[i].e);
    end
    chk(osc_on, 1'b1);
    $display("Test register rows done");
    put(18'h01234, 16'h1235);
    wr(8'h52, 8'h00);
    put(18'h01234, 16'h1200);
    wr(8'h52, 8'h52);
    put(18'h1ffff, 16'h7fff);
    put(18'h20000, 16'h8000);
    put(18'h00000, 16'h0000);
    put(18'h3ffff, 16'hffff);
    $display("Test result codes done");
    for (int i = 0; i < 3; i++) begin
      // Sampling rate stays at its slowest setting
      wr(8'h53, {cd[i], cd[(i + 1) % 3], 4'h0});
      chk(conv_bias, oh[i]);
      chk(amp_bias, oh[(i + 1) % 3]);
      chk(analog_off, 1'b1);
    end
    wr(8'h53, 8'hf1);
    chk(analog_off, 1'b0);
    $display("Test bias done");
    rd(8'h41);
    chk(got, 8'h0a);
    chk(pad, 8'ha5);
    wr(8'h70, 8'h03);
    chk(pad.oe, 4'h4);
    chk({ref_out, ref_in}, 2'h3);
    rd(8'h70);
    chk(got, 8'h83);
    $display("Test pads done");
    @(posedge clk_i);
    bus <= '{addr: 8'h40, wdata: 8'h0f, write: 1'b1, read: 1'b0};
    @(posedge clk_i);
    bus <= '{addr: 8'h40, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clk_i);
    bus.read <= 1'b0;
    #1 chk(rdata, 8'h0f);
    chk(pad, 8'hf0);
    @(posedge clk_i);
    #1 chk(rdata, 8'h00);
    $display("Test back to back done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk({osc_on, pad.out, rdata}, 13'h1000);
    @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rv[i]) begin
      rd(rv[i][15:8]);
      chk(got, rv[i][7:0]);
    end
    chk({conv_bias, amp_bias, analog_off}, {SARB_BIAS_F, SARB_BIAS_F, 1'b1});
    chk({cfg_b, cfg_d}, 16'hf00c);
    chk({cfg_c, 1'b0, cfg_e}, 16'h0000);
    chk({cfg_f, 5'h00, mode_hi}, 16'h0001);
    $display("Test reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
